// [rtl/io_reg_bridge.sv]
// Bridge from the internal main bus to peripheral buses with access timing
// Operation
// R1 - Total cycles: main plus sync plus peripheral
// R2 - Sync only for buses two-six, bus control
// R3 - Main plus sync within one peripheral period
// R4 - Slow system clock: resume next system cycle
// R5 - Bus control: main plus sync within one period
// R6 - Counts hold only without bus contention
// R7 - Master reads back last written register
// R8 - DMA and transfer controller: two system cycles
// R9 - Bus control mode/wait: one or two periods
// R10 - Timer unit: 2-3 peripheral or 2 system
// R11 - Hold master waiting, answer the next cycle
`timescale 1ns/1ps
module io_reg_bridge
  import io_bridge_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              req_i,
  input  wire logic              write_i,
  input  wire logic [23:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              contend_i,
  input  wire logic [DIV_W-1:0]  pclk_ratio_i,
  input  wire logic [DIV_W-1:0]  bclk_ratio_i,
  input  wire logic              sys_slower_i,
  input  wire logic              periph_ready_i,
  input  wire logic [31:0]       periph_rdata_i,
  output logic                   wait_o,
  output logic                   ack_o,
  output logic [31:0]            rdata_o,
  output logic                   periph_sel_o,
  output logic                   periph_write_o,
  output logic [23:0]            periph_addr_o,
  output logic [31:0]            periph_wdata_o,
  output logic [PBUS_W-1:0]      periph_bus_o
);
  import io_bridge_pkg::*;

  typedef struct packed {
    bridge_state_e    state;
    target_e          tgt;
    logic [3:0]       left;
    logic             wait_p;
    logic             ack;
    logic [31:0]      rdata;
    logic             sel;
    logic             write;
    logic [23:0]      addr;
    logic [31:0]      wdata;
    logic [PBUS_W-1:0] pbus;
  } bridge_s;

  bridge_s           cur_ff;
  bridge_s           nxt_cur;
  logic              pclk_edge;
  logic              bclk_edge;
  logic              div_edge;
  target_e           req_tgt;
  logic [PBUS_W-1:0] req_bus;
  logic              req_direct;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic target_e classify(input logic [23:0] a);
    if (in_range(a, DMA_CTRL_BASE, DMA_CTRL_LIMIT) || in_range(a, DXFER_BASE, DXFER_LIMIT)) begin
      return TGT_DIRECT;
    end else if (in_range(a, BUSERR_BASE, BUSERR_LIMIT)) begin
      return TGT_BUSERR;
    end else if (in_range(a, BUSCTL_BASE, BUSCTL_LIMIT)) begin
      return TGT_BUSCTL;
    end else if (in_range(a, TIMER_BASE, TIMER_LIMIT)) begin
      return TGT_TIMER;
    end
    return TGT_PERIPH;
  endfunction

  // Peripheral bus index from address bits [15:12]; direct and bus error targets use PBUS_DIRECT,
  // otherwise values 4'ha and up go to bus 6, all lower values to bus 2 as the catch-all slow bus
  function automatic logic [PBUS_W-1:0] bus_of(input target_e t, input logic [23:0] a);
    if (t == TGT_DIRECT || t == TGT_BUSERR) begin
      return PBUS_DIRECT;
    end else if (a[15:12] >= 4'ha) begin
      return 3'h6;
    end
    return 3'h2;
  endfunction

  // ****************************************************************
  // Peripheral cycles left after the first divided edge
  // ****************************************************************
  // One divided period is already spent on main bus plus sync, so the
  // count starts one below the minimum figure of each target
  function automatic logic [3:0] periph_left(input target_e t);
    unique case (t)
      TGT_BUSCTL: return BUSCTL_MIN_BCLK - 4'h1;  // [R9]
      TGT_TIMER:  return TIMER_MIN_PCLK - 4'h1;   // [R10]
      default:    return PERIPH_MIN_PCLK - 4'h1;
    endcase
  endfunction

  // ****************************************************************
  // Request decode
  // ****************************************************************
  // Decoded once so the idle branch, the bus index and the path choice agree
  assign req_tgt    = classify(addr_i);
  assign req_bus    = bus_of(req_tgt, addr_i);
  assign req_direct = (req_tgt == TGT_DIRECT) || (req_tgt == TGT_BUSERR);

  // ****************************************************************
  // Divided clock phase
  // ****************************************************************
  // Both trackers run free; the sync wait is whatever remains of the
  // current divided period, which keeps main plus sync within one period
  clk_phase_tracker u_pclk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ratio_i (pclk_ratio_i),
    .edge_o  (pclk_edge)
  );

  clk_phase_tracker u_bclk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ratio_i (bclk_ratio_i),
    .edge_o  (bclk_edge)
  );

  assign div_edge = (cur_ff.tgt == TGT_BUSCTL) ? bclk_edge : pclk_edge;

  // ****************************************************************
  // Access sequencing
  // ****************************************************************
  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.ack = 1'b0;
    unique case (cur_ff.state)
      ST_IDLE: begin
        // Main bus cycle takes the request [R1]
        if (req_i && !contend_i) begin  // [R6]
          nxt_cur.tgt    = req_tgt;
          nxt_cur.pbus   = req_bus;  // [R2]
          nxt_cur.write  = write_i;
          nxt_cur.addr   = addr_i;
          nxt_cur.wdata  = write_i ? wdata_i : cur_ff.wdata;
          nxt_cur.wait_p = 1'b1;  // [R11]
          nxt_cur.sel    = 1'b1;
          if (req_direct) begin
            nxt_cur.left  = DIRECT_CYCLES - MAIN_BUS_CYCLES;  // [R8] [R2]
            nxt_cur.state = ST_PBUS;
          end else if (sys_slower_i && req_tgt != TGT_BUSCTL) begin
            // Peripheral finishes inside system cycles, count those [R4] [R10]
            nxt_cur.left  = SLOW_CYCLES - MAIN_BUS_CYCLES;
            nxt_cur.state = ST_PBUS;
          end else begin
            nxt_cur.state = ST_SYNC;  // [R2]
          end
        end
      end
      ST_SYNC: begin
        // Main plus sync ends at the next divided edge, so at most one period [R3] [R5]
        if (div_edge) begin
          nxt_cur.state = ST_PBUS;
          nxt_cur.left  = periph_left(cur_ff.tgt);  // [R9] [R10]
        end
      end
      ST_PBUS: begin
        // Counts divided edges, or system cycles for direct and slow paths [R1]
        // A peripheral that never answers holds the master here; there is
        // no time-out, the far side must always complete
        if (cur_ff.left == 4'h0) begin
          if (periph_ready_i) begin
            nxt_cur.sel   = 1'b0;
            nxt_cur.rdata = cur_ff.write ? cur_ff.rdata : periph_rdata_i;
            nxt_cur.state = ST_DONE;
          end
        end else if (cur_ff.tgt == TGT_DIRECT || cur_ff.tgt == TGT_BUSERR || sys_slower_i
                     || div_edge) begin
          nxt_cur.left = cur_ff.left - 4'h1;
        end
      end
      ST_DONE: begin
        // Answer one cycle after completion, next access may start then [R11] [R4]
        // Select already dropped, so the peripheral sees exactly one access
        nxt_cur.ack    = 1'b1;
        nxt_cur.wait_p = 1'b0;
        nxt_cur.state  = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ff <= '{state: ST_IDLE, tgt: TGT_DIRECT, pbus: PBUS_DIRECT, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign wait_o         = cur_ff.wait_p;
  assign ack_o          = cur_ff.ack;
  assign rdata_o        = cur_ff.rdata;
  assign periph_sel_o   = cur_ff.sel;
  assign periph_write_o = cur_ff.write;
  assign periph_addr_o  = cur_ff.addr;
  assign periph_wdata_o = cur_ff.wdata;
  assign periph_bus_o   = cur_ff.pbus;

endmodule

// [rtl/io_bridge_pkg.sv]
// Constants and types shared by the I/O register access bridge
package io_bridge_pkg;

  // ****************************************************************
  // Address regions (all 24 address bits [23:0] of the register space)
  // ****************************************************************
  localparam logic [23:0] DMA_CTRL_BASE  = 24'h082000;
  localparam logic [23:0] DMA_CTRL_LIMIT = 24'h0823ff;
  localparam logic [23:0] DXFER_BASE     = 24'h082400;
  localparam logic [23:0] DXFER_LIMIT    = 24'h0824ff;
  localparam logic [23:0] BUSCTL_BASE    = 24'h083000;
  localparam logic [23:0] BUSCTL_LIMIT   = 24'h083fff;
  localparam logic [23:0] BUSERR_BASE    = 24'h083800;
  localparam logic [23:0] BUSERR_LIMIT   = 24'h0838ff;
  localparam logic [23:0] TIMER_BASE     = 24'h088100;
  localparam logic [23:0] TIMER_LIMIT    = 24'h0881ff;

  // ****************************************************************
  // Cycle figures
  // ****************************************************************
  localparam logic [3:0] MAIN_BUS_CYCLES   = 4'h1;
  localparam logic [3:0] DIRECT_CYCLES     = 4'h2;
  localparam logic [3:0] TIMER_SLOW_CYCLES = 4'h2;
  localparam logic [3:0] TIMER_MIN_PCLK    = 4'h2;
  localparam logic [3:0] TIMER_MAX_PCLK    = 4'h3;
  localparam logic [3:0] BUSCTL_MIN_BCLK   = 4'h1;
  localparam logic [3:0] BUSCTL_MAX_BCLK   = 4'h2;
  localparam logic [3:0] PERIPH_MIN_PCLK   = 4'h2;
  localparam logic [3:0] PERIPH_MAX_PCLK   = 4'h3;
  localparam logic [3:0] SLOW_CYCLES       = 4'h2;
  localparam int         DIV_W             = 4;
  localparam int         PBUS_W            = 3;
  localparam logic [2:0] PBUS_DIRECT       = 3'h1;

  // ****************************************************************
  // Target classes and bridge states
  // ****************************************************************
  typedef enum logic [2:0] {
    TGT_DIRECT = 3'b000,
    TGT_BUSCTL = 3'b001,
    TGT_BUSERR = 3'b010,
    TGT_TIMER  = 3'b011,
    TGT_PERIPH = 3'b100
  } target_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_PBUS = 2'b10,
    ST_DONE = 2'b11
  } bridge_state_e;

endpackage

// [rtl/clk_phase_tracker.sv]
// Tracks the phase of a divided clock against the system clock
`timescale 1ns/1ps
module clk_phase_tracker
  import io_bridge_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [DIV_W-1:0] ratio_i,
  output logic                  edge_o
);
  import io_bridge_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             edge_p;
  } tracker_s;

  tracker_s cur_ff;
  tracker_s nxt_cur;

  // ******************************************
  // Divided clock edge every ratio_i cycles
  // ******************************************
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.edge_p = 1'b0;
    if ((ratio_i <= 4'h1) || (cur_ff.cnt >= ratio_i - 4'h1)) begin
      nxt_cur.cnt    = '0;
      nxt_cur.edge_p = 1'b1;
    end else begin
      nxt_cur.cnt = cur_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign edge_o = cur_ff.edge_p;

endmodule

// [verif/io_reg_bridge_props.sv]
// Port-level timing checks for the I/O register bridge
`timescale 1ns/1ps
module io_reg_bridge_props
  import io_bridge_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              req_i,
  input wire logic [23:0]       addr_i,
  input wire logic              contend_i,
  input wire logic              sys_slower_i,
  input wire logic              periph_ready_i,
  input wire logic              wait_o,
  input wire logic              ack_o,
  input wire logic              periph_sel_o,
  input wire logic [23:0]       periph_addr_o,
  input wire logic [PBUS_W-1:0] periph_bus_o
);
  logic tk, dir, err, ctl, tmr, pdir, ptmr;
  assign tk   = req_i && !contend_i && !wait_o;
  assign dir  = addr_i >= DMA_CTRL_BASE && addr_i <= DXFER_LIMIT;
  assign err  = addr_i >= BUSERR_BASE && addr_i <= BUSERR_LIMIT;
  assign ctl  = addr_i >= BUSCTL_BASE && addr_i <= BUSCTL_LIMIT && !err;
  assign tmr  = addr_i >= TIMER_BASE && addr_i <= TIMER_LIMIT;
  assign pdir = periph_addr_o >= DMA_CTRL_BASE && periph_addr_o <= DXFER_LIMIT;
  assign ptmr = periph_addr_o >= TIMER_BASE && periph_addr_o <= TIMER_LIMIT;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Targets without sync answer on the fourth edge once the peripheral is ready
  sequence s_fast; tk && (dir || err || (sys_slower_i && !ctl)) ##1 periph_ready_i [*2]; endsequence
  sequence s_answer; !ack_o ##1 ack_o; endsequence
  property p_fast; s_fast |-> ##1 s_answer; endproperty
  property p_timer; tk && tmr && !sys_slower_i |-> ##[3:40] ack_o; endproperty
  property p_busctl; tk && ctl |-> ##[2:40] ack_o; endproperty
  property p_pulse; ack_o |=> !ack_o; endproperty
  property p_wait_end; $fell(wait_o) |-> ack_o; endproperty
  property p_contend; req_i && contend_i && !wait_o && !ack_o |=> !wait_o; endproperty
  property p_copy; $rose(periph_sel_o) |-> periph_addr_o == $past(addr_i); endproperty
  property p_bus; periph_sel_o && (pdir || ptmr) |-> (periph_bus_o == PBUS_DIRECT) == pdir; endproperty
  a_fast: assert property (p_fast) else $error("late fast answer");
  a_timer: assert property (p_timer) else $error("timer access unanswered");
  a_busctl: assert property (p_busctl) else $error("bus control unanswered");
  a_pulse: assert property (p_pulse) else $error("ack too long");
  a_wait_end: assert property (p_wait_end) else $error("wait ended without ack");
  a_contend: assert property (p_contend) else $error("taken while contended");
  a_copy: assert property (p_copy) else $error("address not passed on");
  a_bus: assert property (p_bus) else $error("wrong peripheral bus");
endmodule

bind io_reg_bridge io_reg_bridge_props props (.*);

// [verif/periph_model.sv]
// Peripheral that answers the bridge after a set number of wait cycles
`timescale 1ns/1ps
module periph_model (
  input  wire logic        clk_i,
  input  wire logic        sel_i,
  input  wire logic        write_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [1:0]  delay_i,
  output logic             ready_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [16];
  logic [31:0] last;
  logic [1:0]  cnt = 2'h0;
  assign ready_o = sel_i && cnt >= delay_i;
  // Deselected bus shows the inverse of the last word so stale data cannot pass
  assign rdata_o = sel_i ? mem[addr_i[5:2]] : ~last;
  always @(posedge clk_i) begin
    cnt <= !sel_i ? 2'h0 : cnt + {1'b0, cnt < delay_i};
    if (sel_i) last <= mem[addr_i[5:2]];
    if (ready_o && write_i) mem[addr_i[5:2]] <= wdata_i;
  end
endmodule

// [verif/io_reg_bridge_bench.sv]
// Self-checking bench for the I/O register bridge
`timescale 1ns/1ps
module io_reg_bridge_bench;
  import io_bridge_pkg::*;
  logic              clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, write_i = 1'b0;
  logic              contend_i = 1'b0, sys_slower_i = 1'b0;
  logic              wait_o, ack_o, periph_sel_o, periph_write_o, periph_ready_i;
  logic [1:0]        delay = 2'h0;
  logic [23:0]       addr_i = 24'h0, periph_addr_o;
  logic [31:0]       wdata_i = 32'h0, rdata_o, periph_wdata_o, periph_rdata_i, rd;
  logic [DIV_W-1:0]  pclk_ratio_i = 4'h4, bclk_ratio_i = 4'h3;
  logic [PBUS_W-1:0] periph_bus_o, pb;
  int                fail_count = 0, check_count = 0, cyc = 0, lat, taken;
  io_reg_bridge dut (.*);
  periph_model far_end (.clk_i, .sel_i(periph_sel_o), .write_i(periph_write_o),
    .addr_i(periph_addr_o), .wdata_i(periph_wdata_o), .delay_i(delay),
    .ready_o(periph_ready_i), .rdata_o(periph_rdata_i));
  initial forever #4 clk_i = ~clk_i;
  // Whole run needs under a hundred cycles
  always @(posedge clk_i) if (++cyc == 3000) end_of_test;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) fail_count++;
    if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
  endtask
  task end_of_test;
    if (cyc >= 3000) fail_count++;
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Holds the request until taken; contention is lifted on the third try
  task access(input logic w, input logic [23:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {req_i, write_i, addr_i, wdata_i} <= {1'b1, w, a, d};
    for (taken = 1; taken < 50; taken++) begin
      @(posedge clk_i);
      if (taken == 3) contend_i <= 1'b0;
      #1;
      if (wait_o === 1'b1) break;
    end
    pb = periph_bus_o;
    for (lat = 1; lat < 60; lat++) begin
      @(posedge clk_i);
      req_i <= 1'b0;
      #1;
      if (ack_o === 1'b1) break;
    end
    rd = rdata_o;
  endtask
  task t_direct;
    logic [23:0] a [3];
    a = '{DMA_CTRL_BASE + 24'h4, DXFER_BASE + 24'h8, BUSERR_BASE + 24'hc};
    foreach (a[i]) begin
      access(1'b1, a[i], {8'h5a, a[i]});
      chk("direct latency", {28'h0, MAIN_BUS_CYCLES + DIRECT_CYCLES}, lat);
      chk("direct bus index", {29'h0, PBUS_DIRECT}, {29'h0, pb});
    end
    access(1'b0, a[2], 32'h0);
    chk("read back last write", {8'h5a, a[2]}, rd);
  endtask
  task t_timing;
    @(posedge clk_i) delay <= 2'h3;
    access(1'b1, TIMER_BASE, 32'h0000_00c3);
    // Four peripheral clocks of four cycles, plus the three the peripheral stalls
    chk("timer latency bound", 32'h1, {31'h0, lat > 3 && lat <= 19});
    @(posedge clk_i) {sys_slower_i, delay} <= {1'b1, 2'h0};
    access(1'b0, TIMER_BASE, 32'h0);
    chk("slow clock latency", {28'h0, MAIN_BUS_CYCLES + TIMER_SLOW_CYCLES}, lat);
    chk("timer data", 32'h0000_00c3, rd);
    @(posedge clk_i) sys_slower_i <= 1'b0;
    access(1'b1, BUSCTL_BASE, 32'h0);
    chk("bus control latency bound", 32'h1, {31'h0, lat <= 9});
  endtask
  task t_contend;
    @(posedge clk_i) contend_i <= 1'b1;
    access(1'b0, DMA_CTRL_BASE + 24'h4, 32'h0);
    chk("take held off by contention", 32'h4, taken);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_direct;
    t_timing;
    t_contend;
    end_of_test;
  end
endmodule
